/* File: src/opdec_pkg.sv */
// opcode table, command classes and timing constants of the instruction decoder
// assumes nothing; shared by the decoder top, its shifter and its checker
package opdec_pkg;

   // command classes reported to the core
   typedef enum logic [5:0] {
      CMD_NONE,
      CMD_READ,
      CMD_FAST_READ,
      CMD_DUAL_OUTPUT_READ,
      CMD_QUAD_OUTPUT_READ,
      CMD_DUAL_IO_READ,
      CMD_QUAD_IO_READ,
      CMD_PAGE_WRITE,
      CMD_QUAD_PAGE_WRITE,
      CMD_SMALL_SECTOR_CLEAR,
      CMD_SECTOR_CLEAR,
      CMD_FULL_ARRAY_CLEAR,
      CMD_STATUS_CONFIG_WRITE,
      CMD_FAIL_FLAG_CLEAR,
      CMD_FIRST_STATUS_READ,
      CMD_SECOND_STATUS_READ,
      CMD_CONFIG_READ,
      CMD_LEGACY_SIGNATURE_READ,
      CMD_IDENTITY_READ,
      CMD_PARAMETER_TABLE_READ,
      CMD_BANK_ACCESS,
      CMD_SOFT_RESET,
      CMD_CONTINUOUS_READ_EXIT
   } cmd_type;

   // address forms
   typedef enum logic [1:0] {
      ADDR_NONE,
      ADDR_3_OR_4,
      ADDR_4_ONLY
   } addr_type;

   // opcodes
   localparam logic [7:0] OP_STATUS_CONFIG_WRITE = 8'h01;
   localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_FIRST_STATUS_READ = 8'h05;
   localparam logic [7:0] OP_SECOND_STATUS_READ = 8'h07;
   localparam logic [7:0] OP_FAST_READ = 8'h0b;
   localparam logic [7:0] OP_PAGE_WRITE_WIDE_ADDR = 8'h12;
   localparam logic [7:0] OP_SMALL_SECTOR_CLEAR = 8'h20;
   localparam logic [7:0] OP_SMALL_SECTOR_CLEAR_WIDE = 8'h21;
   localparam logic [7:0] OP_FAIL_FLAG_CLEAR = 8'h30;
   localparam logic [7:0] OP_QUAD_PAGE_WRITE = 8'h32;
   localparam logic [7:0] OP_QUAD_PAGE_WRITE_WIDE = 8'h34;
   localparam logic [7:0] OP_CONFIG_READ = 8'h35;
   localparam logic [7:0] OP_QUAD_PAGE_WRITE_ALT = 8'h38;
   localparam logic [7:0] OP_DUAL_OUTPUT_READ = 8'h3b;
   localparam logic [7:0] OP_DUAL_OUTPUT_READ_WIDE = 8'h3c;
   localparam logic [7:0] OP_PARAMETER_TABLE_READ = 8'h5a;
   localparam logic [7:0] OP_FULL_ARRAY_CLEAR = 8'h60;
   localparam logic [7:0] OP_QUAD_OUTPUT_READ = 8'h6b;
   localparam logic [7:0] OP_QUAD_OUTPUT_READ_WIDE = 8'h6c;
   localparam logic [7:0] OP_LEGACY_SIGNATURE_READ = 8'h90;
   localparam logic [7:0] OP_IDENTITY_READ = 8'h9f;
   localparam logic [7:0] OP_BANK_ACCESS = 8'hb9;
   localparam logic [7:0] OP_DUAL_IO_READ = 8'hbb;
   localparam logic [7:0] OP_DUAL_IO_READ_WIDE = 8'hbc;
   localparam logic [7:0] OP_FULL_ARRAY_CLEAR_ALT = 8'hc7;
   localparam logic [7:0] OP_SECTOR_CLEAR = 8'hd8;
   localparam logic [7:0] OP_SECTOR_CLEAR_WIDE = 8'hdc;
   localparam logic [7:0] OP_QUAD_IO_READ = 8'heb;
   localparam logic [7:0] OP_QUAD_IO_READ_WIDE = 8'hec;
   localparam logic [7:0] OP_SOFT_RESET = 8'hf0;
   localparam logic [7:0] OP_CONTINUOUS_READ_EXIT = 8'hff;

   // highest serial clock rate per command, MHz
   localparam logic [7:0] RATE_SLOW_MHZ = 8'h32;   // 50
   localparam logic [7:0] RATE_QUAD_WRITE_MHZ = 8'h50;   // 80
   localparam logic [7:0] RATE_FULL_MHZ = 8'h6c;   // 108

   // instruction length in serial clock edges
   localparam int OPCODE_BITS = 8;

   // timing
   localparam int SYS_CLK_MHZ = 10;
   localparam int SOFT_RESET_RECOVERY_NS = 35000;
   localparam int SOFT_RESET_RECOVERY_CYCLES =
      (SOFT_RESET_RECOVERY_NS * SYS_CLK_MHZ + 999) / 1000;

endpackage : opdec_pkg

/* File: src/opdec_link_if.sv */
// carries one received opcode from the serial clock domain to the system domain
// assumes a toggle handshake: the link side flips toggle on the same clock edge that loads the payload
`timescale 1ns/10ps
interface opdec_link_if;
   logic [7:0] opcode;
   logic toggle;
   logic in_progress;

   modport link (output opcode, output toggle, output in_progress);
   modport core (input opcode, input toggle, input in_progress);
endinterface : opdec_link_if

/* File: src/opdec_shifter.sv */
// serial clock side: shifts the instruction byte in, msb first
// assumes the serial clock runs only while chip select is low; chip select high resets its bit count, not the captured opcode
`timescale 1ns/10ps
module opdec_shifter (
   // link pins
   input wire logic sck,
   input wire logic cs_n,
   input wire logic data_line_zero,
   // system reset
   input wire logic nrst,
   // towards the decoder
   opdec_link_if.link lnk
);

   logic [6:0] shift_r;
   logic [3:0] count_r;
   logic [7:0] opcode_r;
   logic toggle_r;
   logic active_r;
   logic sel_rst_n;

   // chip select high ends the frame without any further clock edge
   assign sel_rst_n = nrst & ~cs_n;

   always_ff @(posedge sck or negedge sel_rst_n) begin
      if (!sel_rst_n) begin
         shift_r <= 7'h00;
         count_r <= 4'h0;
      end else if (count_r < 4'(opdec_pkg::OPCODE_BITS)) begin
         shift_r <= {shift_r[5:0], data_line_zero};
         count_r <= count_r + 4'h1;
      end
   end

   // later bytes never touch the captured opcode
   always_ff @(posedge sck or negedge nrst) begin
      if (!nrst) begin
         opcode_r <= 8'h00;
         toggle_r <= 1'b0;
      end else if (!cs_n && count_r == 4'(opdec_pkg::OPCODE_BITS - 1)) begin
         opcode_r <= {shift_r, data_line_zero};
         toggle_r <= ~toggle_r;
      end
   end

   always_ff @(posedge sck or negedge sel_rst_n) begin
      if (!sel_rst_n) begin
         active_r <= 1'b0;
      end else begin
         active_r <= 1'b1;
      end
   end

   assign lnk.opcode = opcode_r;
   assign lnk.toggle = toggle_r;
   assign lnk.in_progress = active_r;

endmodule : opdec_shifter

/* File: src/opdec_top.sv */
// instruction decoder of a serial flash: opcode to command class, address form, rate limit
// assumes a host in spi mode 0 or 3; serial clock runs only inside a frame
`timescale 1ns/10ps
module opdec_top #(
   parameter int RECOVERY_CYCLES = opdec_pkg::SOFT_RESET_RECOVERY_CYCLES
) (
   // system
   input wire logic CLK_SYS,
   input wire logic NRST,
   // link pins
   input wire logic SCK,
   input wire logic CS_N,
   input wire logic DATA_LINE_ZERO,
   // decoded command
   output logic CMD_VALID,
   output opdec_pkg::cmd_type CMD,
   output opdec_pkg::addr_type ADDR_FORM,
   output logic [7:0] MAX_RATE_MHZ,
   output logic [7:0] OPCODE,
   output logic CMD_IGNORED,
   // soft reset
   output logic SOFT_RESET,
   output logic BUSY
);

   // one row of the opcode table
   typedef struct packed {
      opdec_pkg::cmd_type cmd;
      opdec_pkg::addr_type form;
      logic [7:0] rate;
   } dec_type;

   // frame progress as seen from the system clock
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_FRAME,
      ST_RECOVER
   } state_type;

   // serial side: the only logic clocked by the link clock
   opdec_link_if lnk ();

   opdec_shifter u_shifter (
      .sck(SCK),
      .cs_n(CS_N),
      .data_line_zero(DATA_LINE_ZERO),
      .nrst(NRST),
      .lnk(lnk)
   );

   // opcode table
   function automatic dec_type decode(input logic [7:0] op);
      dec_type d;
      // defaults: no command, no address, full rate
      d = '{opdec_pkg::CMD_NONE, opdec_pkg::ADDR_NONE, opdec_pkg::RATE_FULL_MHZ};
      case (op)
         opdec_pkg::OP_READ:
            d = '{opdec_pkg::CMD_READ, opdec_pkg::ADDR_3_OR_4,
                  opdec_pkg::RATE_SLOW_MHZ};
         opdec_pkg::OP_FAST_READ:
            d.cmd = opdec_pkg::CMD_FAST_READ;
         opdec_pkg::OP_DUAL_OUTPUT_READ, opdec_pkg::OP_DUAL_OUTPUT_READ_WIDE:
            d.cmd = opdec_pkg::CMD_DUAL_OUTPUT_READ;
         opdec_pkg::OP_QUAD_OUTPUT_READ, opdec_pkg::OP_QUAD_OUTPUT_READ_WIDE:
            d.cmd = opdec_pkg::CMD_QUAD_OUTPUT_READ;
         opdec_pkg::OP_DUAL_IO_READ, opdec_pkg::OP_DUAL_IO_READ_WIDE:
            d.cmd = opdec_pkg::CMD_DUAL_IO_READ;
         opdec_pkg::OP_QUAD_IO_READ, opdec_pkg::OP_QUAD_IO_READ_WIDE:
            d.cmd = opdec_pkg::CMD_QUAD_IO_READ;
         opdec_pkg::OP_PAGE_WRITE, opdec_pkg::OP_PAGE_WRITE_WIDE_ADDR:
            d.cmd = opdec_pkg::CMD_PAGE_WRITE;
         opdec_pkg::OP_QUAD_PAGE_WRITE, opdec_pkg::OP_QUAD_PAGE_WRITE_ALT,
         opdec_pkg::OP_QUAD_PAGE_WRITE_WIDE:
            d = '{opdec_pkg::CMD_QUAD_PAGE_WRITE, opdec_pkg::ADDR_NONE,
                  opdec_pkg::RATE_QUAD_WRITE_MHZ};
         opdec_pkg::OP_SMALL_SECTOR_CLEAR, opdec_pkg::OP_SMALL_SECTOR_CLEAR_WIDE:
            d.cmd = opdec_pkg::CMD_SMALL_SECTOR_CLEAR;
         opdec_pkg::OP_SECTOR_CLEAR, opdec_pkg::OP_SECTOR_CLEAR_WIDE:
            d.cmd = opdec_pkg::CMD_SECTOR_CLEAR;
         opdec_pkg::OP_FULL_ARRAY_CLEAR, opdec_pkg::OP_FULL_ARRAY_CLEAR_ALT:
            d.cmd = opdec_pkg::CMD_FULL_ARRAY_CLEAR;
         opdec_pkg::OP_STATUS_CONFIG_WRITE:
            d.cmd = opdec_pkg::CMD_STATUS_CONFIG_WRITE;
         opdec_pkg::OP_FAIL_FLAG_CLEAR:
            d.cmd = opdec_pkg::CMD_FAIL_FLAG_CLEAR;
         opdec_pkg::OP_FIRST_STATUS_READ:
            d.cmd = opdec_pkg::CMD_FIRST_STATUS_READ;
         opdec_pkg::OP_SECOND_STATUS_READ:
            d.cmd = opdec_pkg::CMD_SECOND_STATUS_READ;
         opdec_pkg::OP_CONFIG_READ:
            d.cmd = opdec_pkg::CMD_CONFIG_READ;
         opdec_pkg::OP_LEGACY_SIGNATURE_READ:
            d.cmd = opdec_pkg::CMD_LEGACY_SIGNATURE_READ;
         opdec_pkg::OP_IDENTITY_READ:
            d.cmd = opdec_pkg::CMD_IDENTITY_READ;
         opdec_pkg::OP_PARAMETER_TABLE_READ:
            d.cmd = opdec_pkg::CMD_PARAMETER_TABLE_READ;
         opdec_pkg::OP_BANK_ACCESS:
            d.cmd = opdec_pkg::CMD_BANK_ACCESS;
         opdec_pkg::OP_SOFT_RESET:
            d.cmd = opdec_pkg::CMD_SOFT_RESET;
         opdec_pkg::OP_CONTINUOUS_READ_EXIT:
            d.cmd = opdec_pkg::CMD_CONTINUOUS_READ_EXIT;
         default:
            d.cmd = opdec_pkg::CMD_NONE;
      endcase
      // address form follows from the opcode itself
      case (op)
         opdec_pkg::OP_READ, opdec_pkg::OP_FAST_READ, opdec_pkg::OP_DUAL_OUTPUT_READ,
         opdec_pkg::OP_QUAD_OUTPUT_READ, opdec_pkg::OP_DUAL_IO_READ,
         opdec_pkg::OP_QUAD_IO_READ, opdec_pkg::OP_PAGE_WRITE,
         opdec_pkg::OP_QUAD_PAGE_WRITE, opdec_pkg::OP_QUAD_PAGE_WRITE_ALT,
         opdec_pkg::OP_SMALL_SECTOR_CLEAR, opdec_pkg::OP_SECTOR_CLEAR:
            d.form = opdec_pkg::ADDR_3_OR_4;
         opdec_pkg::OP_DUAL_OUTPUT_READ_WIDE, opdec_pkg::OP_QUAD_OUTPUT_READ_WIDE,
         opdec_pkg::OP_DUAL_IO_READ_WIDE, opdec_pkg::OP_QUAD_IO_READ_WIDE,
         opdec_pkg::OP_PAGE_WRITE_WIDE_ADDR, opdec_pkg::OP_QUAD_PAGE_WRITE_WIDE,
         opdec_pkg::OP_SMALL_SECTOR_CLEAR_WIDE, opdec_pkg::OP_SECTOR_CLEAR_WIDE:
            d.form = opdec_pkg::ADDR_4_ONLY;
         default:
            d.form = opdec_pkg::ADDR_NONE;
      endcase
      return d;
   endfunction : decode

   // true for reserved and unknown opcodes, which raise the ignore strobe rather than the valid strobe
   function automatic logic is_noop(input dec_type d);
      return (d.cmd == opdec_pkg::CMD_NONE);
   endfunction : is_noop

   // crossings: the opcode word settles a full sync delay before its toggle is seen,
   // so it is read directly in the event cycle without a second copy
   logic tog_meta_r;
   logic tog_sync_r;
   logic tog_seen_r;
   logic act_meta_r;
   logic act_sync_r;
   logic op_event;

   // toggle of the shifter; nothing but the second stage reads the first
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         tog_meta_r <= 1'b0;
         tog_sync_r <= 1'b0;
         tog_seen_r <= 1'b0;
      end else begin
         tog_meta_r <= lnk.toggle;
         tog_sync_r <= tog_meta_r;
         tog_seen_r <= tog_sync_r;
      end
   end

   // frame level; the chip select rise reaches here two edges late
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         act_meta_r <= 1'b0;
         act_sync_r <= 1'b0;
      end else begin
         act_meta_r <= lnk.in_progress;
         act_sync_r <= act_meta_r;
      end
   end

   // both toggles start at zero, so no false event follows reset
   assign op_event = tog_sync_r ^ tog_seen_r;

   // frame tracking and soft reset
   state_type state_r, state_nxt;
   logic reset_pending_r;
   logic [31:0] recover_cnt_r;
   dec_type dec_now;
   logic frame_end;
   logic accept;

   // the opcode word is only looked at in the event cycle, when it is settled
   assign dec_now = decode(lnk.opcode);
   // a frame ends once its synchronised level drops; an event in that cycle
   // keeps it open for one more cycle
   assign frame_end = (state_r == ST_FRAME) && !act_sync_r && !op_event;
   // opcodes that arrive during recovery are dropped whole
   assign accept = op_event && (state_r != ST_RECOVER);

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (op_event) begin
               state_nxt = ST_FRAME;
            end
         end
         ST_FRAME: begin
            // a frame that carried a soft reset ends in the recovery wait
            if (frame_end) begin
               state_nxt = reset_pending_r ? ST_RECOVER : ST_IDLE;
            end
         end
         ST_RECOVER: begin
            if (recover_cnt_r == 32'h0) begin
               state_nxt = ST_IDLE;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // remembers whether the frame now open carried a soft reset
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         reset_pending_r <= 1'b0;
      end else if (accept) begin
         reset_pending_r <= (dec_now.cmd == opdec_pkg::CMD_SOFT_RESET);
      end else if (frame_end) begin
         reset_pending_r <= 1'b0;
      end
   end

   // counts down to zero; busy lasts RECOVERY_CYCLES cycles in all
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         recover_cnt_r <= 32'h0;
      end else if (frame_end && reset_pending_r) begin
         recover_cnt_r <= 32'(RECOVERY_CYCLES - 1);
      end else if (state_r == ST_RECOVER && recover_cnt_r != 32'h0) begin
         recover_cnt_r <= recover_cnt_r - 32'h1;
      end
   end

   // strobes: one cycle each, never both at once
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         CMD_VALID <= 1'b0;
         CMD_IGNORED <= 1'b0;
      end else begin
         CMD_VALID <= accept && !is_noop(dec_now);
         CMD_IGNORED <= accept && is_noop(dec_now);
      end
   end

   // decoded fields hold until the next accepted opcode
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         CMD <= opdec_pkg::CMD_NONE;
         ADDR_FORM <= opdec_pkg::ADDR_NONE;
         MAX_RATE_MHZ <= 8'h00;
         OPCODE <= 8'h00;
      end else if (accept) begin
         CMD <= dec_now.cmd;
         ADDR_FORM <= dec_now.form;
         MAX_RATE_MHZ <= dec_now.rate;
         OPCODE <= lnk.opcode;
      end
   end

   // soft reset strobe is combinational so that busy follows it in the very next cycle
   assign SOFT_RESET = frame_end && reset_pending_r;

   // busy follows the next state, so it matches the state register exactly
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         BUSY <= 1'b0;
      end else begin
         BUSY <= (state_nxt == ST_RECOVER);
      end
   end

endmodule : opdec_top

/* File: sim/opdec_props.sv */
// checker of the instruction decoder outputs
// assumes binding to opdec_top; sees only its ports
`timescale 1ns/10ps
module opdec_props #(
   parameter int RECOVERY_CYCLES = 8
) (
   // system
   input wire logic CLK_SYS,
   input wire logic NRST,
   // link pins
   input wire logic SCK,
   input wire logic CS_N,
   input wire logic DATA_LINE_ZERO,
   // decoded command
   input wire logic CMD_VALID,
   input wire opdec_pkg::cmd_type CMD,
   input wire opdec_pkg::addr_type ADDR_FORM,
   input wire logic [7:0] MAX_RATE_MHZ,
   input wire logic [7:0] OPCODE,
   input wire logic CMD_IGNORED,
   // soft reset
   input wire logic SOFT_RESET,
   input wire logic BUSY
);
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!NRST);
   // length of the current busy stretch, judged when it ends
   int busy_len_r;
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) busy_len_r <= 0;
      else if (BUSY) busy_len_r <= busy_len_r + 1;
      else busy_len_r <= 0;
   end
   property p_excl;
      !(CMD_VALID && CMD_IGNORED);
   endproperty
   a_excl: assert property (p_excl) else $error("valid and ignored together");
   property p_pulse;
      CMD_VALID |=> !CMD_VALID;
   endproperty
   a_pulse: assert property (p_pulse) else $error("valid longer than one cycle");
   property p_read;
      CMD_VALID && OPCODE == 8'h03 |-> CMD == opdec_pkg::CMD_READ && MAX_RATE_MHZ == 8'h32;
   endproperty
   a_read: assert property (p_read) else $error("normal read decode wrong");
   property p_qpp;
      CMD_VALID && OPCODE inside {8'h32, 8'h38} |-> CMD == opdec_pkg::CMD_QUAD_PAGE_WRITE
         && ADDR_FORM == opdec_pkg::ADDR_3_OR_4 && MAX_RATE_MHZ == 8'h50;
   endproperty
   a_qpp: assert property (p_qpp) else $error("quad page write decode wrong");
   property p_dual_wide;
      CMD_VALID && OPCODE == 8'h3c |-> CMD == opdec_pkg::CMD_DUAL_OUTPUT_READ
         && ADDR_FORM == opdec_pkg::ADDR_4_ONLY;
   endproperty
   a_dual_wide: assert property (p_dual_wide) else $error("dual read wide decode wrong");
   property p_bank;
      CMD_VALID && OPCODE == 8'hb9 |-> CMD == opdec_pkg::CMD_BANK_ACCESS;
   endproperty
   a_bank: assert property (p_bank) else $error("bank access decode wrong");
   property p_hold;
      CMD != $past(CMD) |-> CMD_VALID || CMD_IGNORED;
   endproperty
   a_hold: assert property (p_hold) else $error("command changed without a pulse");
   property p_refuse;
      BUSY |-> !CMD_VALID && !CMD_IGNORED;
   endproperty
   a_refuse: assert property (p_refuse) else $error("opcode taken while busy");
   property p_soft_cs;
      SOFT_RESET |-> CS_N;
   endproperty
   a_soft_cs: assert property (p_soft_cs) else $error("soft reset inside a frame");
   property p_soft_busy;
      SOFT_RESET |=> !SOFT_RESET && BUSY;
   endproperty
   a_soft_busy: assert property (p_soft_busy) else $error("busy not after soft reset");
   property p_busy_len;
      $fell(BUSY) |-> busy_len_r == RECOVERY_CYCLES;
   endproperty
   a_busy_len: assert property (p_busy_len) else $error("recovery length wrong");
endmodule : opdec_props

bind opdec_top opdec_props #(.RECOVERY_CYCLES(RECOVERY_CYCLES)) opdec_props_i (
   .CLK_SYS(CLK_SYS), .NRST(NRST), .SCK(SCK), .CS_N(CS_N), .DATA_LINE_ZERO(DATA_LINE_ZERO),
   .CMD_VALID(CMD_VALID), .CMD(CMD), .ADDR_FORM(ADDR_FORM), .MAX_RATE_MHZ(MAX_RATE_MHZ),
   .OPCODE(OPCODE), .CMD_IGNORED(CMD_IGNORED), .SOFT_RESET(SOFT_RESET), .BUSY(BUSY));

/* File: sim/spi_host_model.sv */
// host side model: drives chip select, serial clock and data line zero
// assumes spi mode 0; the bench calls frame() and waits for it to return
`timescale 1ns/10ps
module spi_host_model #(
   parameter int HALF_NS = 32
) (
   // link pins
   output logic sck,
   output logic cs_n,
   output logic data_line_zero
);
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      data_line_zero = 1'b0;
   end
   // sends the first n bits of bits, msb first; clock stands still outside the frame
   task automatic frame(input logic [15:0] bits, input int n);
      int k;
      #13 cs_n = 1'b0;
      #40;
      for (k = 0; k < n; k++) begin
         data_line_zero = bits[15 - k];
         #HALF_NS sck = 1'b1;
         #HALF_NS sck = 1'b0;
      end
      // released line shows the inverse, never a stale copy
      data_line_zero = ~data_line_zero;
      #500 cs_n = 1'b1;
      #400;
   endtask : frame
endmodule : spi_host_model

/* File: sim/tb.sv */
// self-checking bench of the instruction decoder
// assumes opdec_top, its checker bind and the host model are compiled first
`timescale 1ns/10ps
module tb;
   typedef struct packed {
      opdec_pkg::cmd_type c;
      opdec_pkg::addr_type a;
      logic [7:0] r;
   } exp_type;
   // longer than a frame so that a follow-up opcode lands inside the wait
   localparam int RECOVERY = 20;
   logic CLK_SYS = 1'b0;
   logic NRST = 1'b0;
   logic SCK, CS_N, DATA_LINE_ZERO, CMD_VALID, CMD_IGNORED, SOFT_RESET, BUSY;
   opdec_pkg::cmd_type CMD;
   opdec_pkg::addr_type ADDR_FORM;
   logic [7:0] MAX_RATE_MHZ, OPCODE;
   int failures = 0;
   int num_checks = 0;
   int n_valid, n_ign, n_soft, n_busy;
   int cycles = 0;
   logic [7:0] ops [31] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h07, 8'h0b, 8'h12, 8'h20, 8'h21,
      8'h30, 8'h32, 8'h34, 8'h35, 8'h38, 8'h3b, 8'h3c, 8'h5a, 8'h60, 8'h6b, 8'h6c, 8'h90,
      8'h9f, 8'hb9, 8'hbb, 8'hbc, 8'hc7, 8'hd8, 8'hdc, 8'heb, 8'hec, 8'hff};
   opdec_top #(.RECOVERY_CYCLES(RECOVERY)) opdec_top_i (.CLK_SYS(CLK_SYS), .NRST(NRST),
      .SCK(SCK), .CS_N(CS_N), .DATA_LINE_ZERO(DATA_LINE_ZERO), .CMD_VALID(CMD_VALID),
      .CMD(CMD), .ADDR_FORM(ADDR_FORM), .MAX_RATE_MHZ(MAX_RATE_MHZ), .OPCODE(OPCODE),
      .CMD_IGNORED(CMD_IGNORED), .SOFT_RESET(SOFT_RESET), .BUSY(BUSY));
   spi_host_model spi_host_model_i (.sck(SCK), .cs_n(CS_N), .data_line_zero(DATA_LINE_ZERO));
   initial forever #50 CLK_SYS = ~CLK_SYS;
   always @(negedge CLK_SYS) begin
      if (CMD_VALID === 1'b1) n_valid++;
      if (CMD_IGNORED === 1'b1) n_ign++;
      if (SOFT_RESET === 1'b1) n_soft++;
      if (BUSY === 1'b1) n_busy++;
   end
   always @(posedge CLK_SYS) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : tally_and_finish
   task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_val
   task automatic chk_cmd(input opdec_pkg::cmd_type got, input opdec_pkg::cmd_type exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_cmd
   function automatic exp_type expect_of(input logic [7:0] op);
      exp_type e;
      case (op)
         8'h03: e.c = opdec_pkg::CMD_READ;
         8'h0b: e.c = opdec_pkg::CMD_FAST_READ;
         8'h3b, 8'h3c: e.c = opdec_pkg::CMD_DUAL_OUTPUT_READ;
         8'h6b, 8'h6c: e.c = opdec_pkg::CMD_QUAD_OUTPUT_READ;
         8'hbb, 8'hbc: e.c = opdec_pkg::CMD_DUAL_IO_READ;
         8'heb, 8'hec: e.c = opdec_pkg::CMD_QUAD_IO_READ;
         8'h02, 8'h12: e.c = opdec_pkg::CMD_PAGE_WRITE;
         8'h32, 8'h34, 8'h38: e.c = opdec_pkg::CMD_QUAD_PAGE_WRITE;
         8'h20, 8'h21: e.c = opdec_pkg::CMD_SMALL_SECTOR_CLEAR;
         8'hd8, 8'hdc: e.c = opdec_pkg::CMD_SECTOR_CLEAR;
         8'h60, 8'hc7: e.c = opdec_pkg::CMD_FULL_ARRAY_CLEAR;
         8'h01: e.c = opdec_pkg::CMD_STATUS_CONFIG_WRITE;
         8'h30: e.c = opdec_pkg::CMD_FAIL_FLAG_CLEAR;
         8'h05: e.c = opdec_pkg::CMD_FIRST_STATUS_READ;
         8'h07: e.c = opdec_pkg::CMD_SECOND_STATUS_READ;
         8'h35: e.c = opdec_pkg::CMD_CONFIG_READ;
         8'h90: e.c = opdec_pkg::CMD_LEGACY_SIGNATURE_READ;
         8'h9f: e.c = opdec_pkg::CMD_IDENTITY_READ;
         8'h5a: e.c = opdec_pkg::CMD_PARAMETER_TABLE_READ;
         8'hb9: e.c = opdec_pkg::CMD_BANK_ACCESS;
         default: e.c = opdec_pkg::CMD_CONTINUOUS_READ_EXIT;
      endcase
      e.r = (op == 8'h03) ? 8'h32 : (op inside {8'h32, 8'h34, 8'h38}) ? 8'h50 : 8'h6c;
      if (op inside {8'h12, 8'h21, 8'h34, 8'h3c, 8'h6c, 8'hbc, 8'hdc, 8'hec})
         e.a = opdec_pkg::ADDR_4_ONLY;
      else if (op inside {8'h02, 8'h03, 8'h0b, 8'h20, 8'h32, 8'h38, 8'h3b, 8'h6b, 8'hbb,
            8'hd8, 8'heb}) e.a = opdec_pkg::ADDR_3_OR_4;
      else e.a = opdec_pkg::ADDR_NONE;
      return e;
   endfunction : expect_of
   task automatic run(input logic [15:0] bits, input int n);
      n_valid = 0;
      n_ign = 0;
      n_soft = 0;
      spi_host_model_i.frame(bits, n);
      repeat (5) @(negedge CLK_SYS);
   endtask : run
   task automatic t_reset();
      chk_val({7'h00, CMD_VALID}, 8'h00);
      chk_cmd(CMD, opdec_pkg::CMD_NONE);
      chk_val({7'h00, BUSY}, 8'h00);
      $display("test reset values done");
   endtask : t_reset
   task automatic t_table();
      exp_type e;
      foreach (ops[i]) begin
         e = expect_of(ops[i]);
         run({ops[i], 8'h00}, 8);
         chk_val(8'(n_valid), 8'h01);
         chk_val(8'(n_ign), 8'h00);
         chk_cmd(CMD, e.c);
         chk_val(MAX_RATE_MHZ, e.r);
         chk_val(OPCODE, ops[i]);
         chk_val({6'h00, ADDR_FORM}, {6'h00, e.a});
      end
      $display("test opcode table done");
   endtask : t_table
   task automatic t_unknown();
      logic [7:0] bad [4] = '{8'ha3, 8'he5, 8'he6, 8'h04};
      foreach (bad[i]) begin
         run({bad[i], 8'h00}, 8);
         chk_val(8'({n_ign[3:0], n_valid[3:0]}), 8'h10);
      end
      run({8'ha3, 8'h05}, 16);
      chk_val(8'({n_ign[3:0], n_valid[3:0]}), 8'h10);
      $display("test unknown opcodes done");
   endtask : t_unknown
   task automatic t_frame();
      run({8'h03, 8'h00}, 7);
      chk_val(8'({n_ign[3:0], n_valid[3:0]}), 8'h00);
      run({8'h05, 8'h03}, 16);
      chk_val(8'({n_ign[3:0], n_valid[3:0]}), 8'h01);
      chk_cmd(CMD, opdec_pkg::CMD_FIRST_STATUS_READ);
      $display("test frame length done");
   endtask : t_frame
   task automatic t_soft();
      int k;
      n_busy = 0;
      run({8'hf0, 8'h00}, 8);
      chk_cmd(CMD, opdec_pkg::CMD_SOFT_RESET);
      chk_val(8'(n_soft), 8'h01);
      run({8'h05, 8'h00}, 8);
      chk_val(8'({n_ign[3:0], n_valid[3:0]}), 8'h00);
      chk_cmd(CMD, opdec_pkg::CMD_SOFT_RESET);
      for (k = 0; k < 100 && BUSY === 1'b1; k++) @(negedge CLK_SYS);
      chk_val(8'(n_busy), 8'(RECOVERY));
      run({8'h07, 8'h00}, 8);
      chk_cmd(CMD, opdec_pkg::CMD_SECOND_STATUS_READ);
      $display("test soft reset done");
   endtask : t_soft
   initial begin
      repeat (12) @(negedge CLK_SYS);
      NRST = 1'b1;
      @(negedge CLK_SYS);
      t_reset();
      t_table();
      t_unknown();
      t_frame();
      t_soft();
      tally_and_finish();
   end
endmodule : tb
